// file: design/alpr_map.svh
// constant map for the alarm log and parameter read block
`ifndef ALPR_MAP_SVH
`define ALPR_MAP_SVH
`define ALPR_ALARM_W 8
`define ALPR_ALARM_N 3
`define ALPR_CODE_W 16
`define ALPR_VALUE_W 16
`define ALPR_GRP_MSB 15
`define ALPR_GRP_LSB 8
`define ALPR_NUM_MSB 7
`define ALPR_NUM_LSB 0
`define ALPR_VALUE_NONE 16'h0000
`define ALPR_ALARM_RST 8'h00
`define ALPR_INT_RST 24'h000000
`endif

// file: design/alpr_pkg.sv
// types for the alarm log and parameter read block
package alpr_pkg;
    typedef enum logic [1:0] {
        ALPR_IDLE,
        ALPR_WAIT
    } alpr_state_e;
    typedef logic [7:0] alpr_byte_t;
endpackage

// file: design/alpr_param_link.sv
// parameter fetch link: holds one request toward the parameter store
`timescale 1ns/1ns
`default_nettype none
`include "alpr_map.svh"
module alpr_param_link #(
    parameter int CODE_W = `ALPR_CODE_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [CODE_W-1:0] code,
    input wire logic store_ack,
    output logic store_req,
    output logic [CODE_W-1:0] store_code
);
    logic req_q;
    logic req_d;
    logic [CODE_W-1:0] code_q;
    logic [CODE_W-1:0] code_d;

    always_comb begin
        req_d = req_q;
        code_d = code_q;
        if (start) begin
            req_d = 1'b1;
            code_d = code;
        end else if (store_ack) begin
            req_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            req_q <= 1'b0;
            code_q <= '0;
        end else begin
            req_q <= req_d;
            code_q <= code_d;
        end
    end

    assign store_req = req_q;
    assign store_code = code_q;
endmodule
`default_nettype wire

// file: design/alpr_top.sv
// alarm history publisher and parameter read interpreter
// Function
// - the alarm history output holds three one-byte codes: newest, second, third.
// - each byte is an unsigned code 0 to 255 and the first byte holds the newest alarm.
// - the history is sent on change, or after the minimum send interval when one is set.
// - a write of a 16-bit read code by the remote node starts a readout.
// - the parameter value goes out on the read value output, which ends the readout.
// - a parameter that does not exist returns zero.
// - a read request that arrives during a readout is dropped.
// - no busy indication is given to the network.
`timescale 1ns/1ns
`default_nettype none
`include "alpr_map.svh"
module alpr_top
    import alpr_pkg::*;
#(
    parameter int ALARM_W = `ALPR_ALARM_W,
    parameter int CODE_W = `ALPR_CODE_W,
    parameter int VALUE_W = `ALPR_VALUE_W,
    parameter int INTERVAL_W = 24
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic alarm_new,
    input wire alpr_pkg::alpr_byte_t alarm_code,
    input wire logic [INTERVAL_W-1:0] min_send_interval,
    output logic [3*ALARM_W-1:0] alarm_history_output,
    output logic alarm_history_send,
    input wire logic param_read_code_wr,
    input wire logic [CODE_W-1:0] param_read_code_input,
    output logic store_req,
    output logic [7:0] store_group,
    output logic [7:0] store_number,
    input wire logic store_ack,
    input wire logic store_exists,
    input wire logic [VALUE_W-1:0] store_value,
    output logic [VALUE_W-1:0] param_read_value_output,
    output logic param_read_value_valid
);
    import alpr_pkg::*;

    // local copies of the history geometry and code field positions
    localparam int HIST_N = `ALPR_ALARM_N;
    localparam int GRP_MSB = `ALPR_GRP_MSB;
    localparam int GRP_LSB = `ALPR_GRP_LSB;
    localparam int NUM_MSB = `ALPR_NUM_MSB;
    localparam int NUM_LSB = `ALPR_NUM_LSB;

    // true when shifting the new code in alters the published history
    function automatic logic hist_changed(
        input logic [ALARM_W-1:0] code,
        input logic [ALARM_W-1:0] h0,
        input logic [ALARM_W-1:0] h1,
        input logic [ALARM_W-1:0] h2
    );
        logic diff;
        diff = (code != h0) || (h0 != h1) || (h1 != h2);
        return diff;
    endfunction

    // read code field decoders
    function automatic logic [7:0] code_group(input logic [CODE_W-1:0] code);
        return code[GRP_MSB:GRP_LSB];
    endfunction

    function automatic logic [7:0] code_number(input logic [CODE_W-1:0] code);
        return code[NUM_MSB:NUM_LSB];
    endfunction

    // alarm history shift register
    logic [ALARM_W-1:0] hist_q [HIST_N];
    logic [ALARM_W-1:0] hist_d [HIST_N];
    logic pend_q;
    logic pend_d;
    logic send_q;
    logic send_d;
    logic [INTERVAL_W-1:0] gap_q;
    logic [INTERVAL_W-1:0] gap_d;

    always_comb begin
        hist_d = hist_q;
        if (alarm_new) begin
            hist_d[0] = alarm_code;
            for (int i = 1; i < HIST_N; i++) begin
                hist_d[i] = hist_q[i-1];
            end
        end
    end

    // send pacing: immediate when no interval is set or the gap has run out, otherwise held off
    always_comb begin
        pend_d = pend_q;
        send_d = 1'b0;
        gap_d = gap_q;
        if (gap_q != '0) begin
            gap_d = gap_q - 1'b1;
        end
        if (pend_q && (min_send_interval == '0 || gap_q == '0)) begin
            send_d = 1'b1;
            pend_d = 1'b0;
            gap_d = min_send_interval;
        end
        // a change in the sending cycle stays pending so it is not lost;
        // the send then carries the newer content once the gap expires
        if (alarm_new && hist_changed(alarm_code, hist_q[0], hist_q[1], hist_q[2])) begin
            pend_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < HIST_N; i++) begin
                hist_q[i] <= `ALPR_ALARM_RST;
            end
        end else begin
            hist_q <= hist_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_q <= 1'b0;
            send_q <= 1'b0;
            gap_q <= INTERVAL_W'(`ALPR_INT_RST);
        end else begin
            pend_q <= pend_d;
            send_q <= send_d;
            gap_q <= gap_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < HIST_N; g++) begin : g_pack
            assign alarm_history_output[(HIST_N-g)*ALARM_W-1 -: ALARM_W] = hist_q[g];
        end
    endgenerate
    assign alarm_history_send = send_q;

    // parameter readout
    alpr_state_e state_q;
    alpr_state_e state_d;
    logic start;
    logic [CODE_W-1:0] link_code;
    logic [VALUE_W-1:0] val_q;
    logic [VALUE_W-1:0] val_d;
    logic vld_q;
    logic vld_d;

    // one readout at a time: with no busy flag the remote side cannot tell,
    // so a write during a readout is dropped rather than queued
    always_comb begin
        state_d = state_q;
        start = 1'b0;
        case (state_q)
            ALPR_IDLE: begin
                if (param_read_code_wr) begin
                    start = 1'b1;
                    state_d = ALPR_WAIT;
                end
            end
            ALPR_WAIT: begin
                // further writes here are dropped
                if (store_ack) begin
                    state_d = ALPR_IDLE;
                end
            end
            default: state_d = ALPR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ALPR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // result register: loads once at the end of each readout
    always_comb begin
        val_d = val_q;
        vld_d = 1'b0;
        if (state_q == ALPR_WAIT && store_ack) begin
            val_d = store_exists ? store_value : `ALPR_VALUE_NONE;
            vld_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            val_q <= `ALPR_VALUE_NONE;
            vld_q <= 1'b0;
        end else begin
            val_q <= val_d;
            vld_q <= vld_d;
        end
    end

    alpr_param_link #(
        .CODE_W(CODE_W)
    ) u_link (
        .clk(clk),
        .nrst(nrst),
        .start(start),
        .code(param_read_code_input),
        .store_ack(store_ack),
        .store_req(store_req),
        .store_code(link_code)
    );

    assign store_group = code_group(link_code);
    assign store_number = code_number(link_code);
    assign param_read_value_output = val_q;
    // value and valid are the only readout outputs, there is no busy flag
    assign param_read_value_valid = vld_q;
endmodule
`default_nettype wire

// file: sim/alpr_checker.sv
// port assertions for the alarm log and parameter read block
`timescale 1ns/1ns
`default_nettype none
module alpr_checker #(
    parameter int INTERVAL_W = 24
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic alarm_new,
    input wire alpr_pkg::alpr_byte_t alarm_code,
    input wire logic [INTERVAL_W-1:0] min_send_interval,
    input wire logic [23:0] alarm_history_output,
    input wire logic alarm_history_send,
    input wire logic param_read_code_wr,
    input wire logic [15:0] param_read_code_input,
    input wire logic store_req,
    input wire logic [7:0] store_group,
    input wire logic [7:0] store_number,
    input wire logic store_ack,
    input wire logic store_exists,
    input wire logic [15:0] store_value,
    input wire logic [15:0] param_read_value_output,
    input wire logic param_read_value_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_hist_shift: assert property (alarm_new |=> alarm_history_output ==
        {$past(alarm_code), $past(alarm_history_output[23:8])}) else $error("no shift");
    a_send_change: assert property (alarm_new && min_send_interval == 0 &&
        {alarm_code, alarm_history_output[23:8]} != alarm_history_output
        |-> ##2 alarm_history_send) else $error("no send");
    a_read_start: assert property (param_read_code_wr && !store_req |=> store_req)
        else $error("no start");
    a_code_split: assert property ($rose(store_req) |->
        {store_group, store_number} == $past(param_read_code_input)) else $error("split");
    a_value_out: assert property (store_req && store_ack && store_exists |=>
        param_read_value_valid && param_read_value_output == $past(store_value))
        else $error("value");
    a_absent_zero: assert property (store_req && store_ack && !store_exists |=>
        param_read_value_valid && param_read_value_output == 16'h0000) else $error("zero");
    a_busy_drop: assert property (store_req && param_read_code_wr |=>
        $stable({store_group, store_number})) else $error("not dropped");
    a_valid_end: assert property (param_read_value_valid |-> !store_req ##1
        !param_read_value_valid) else $error("valid");
    c_absent: cover property (store_req && store_ack && !store_exists);
    c_drop: cover property (store_req && param_read_code_wr);
    c_send: cover property (alarm_history_send);
endmodule
`default_nettype wire

// file: sim/alpr_store_model.sv
// parameter store partner: answers after a set delay
`timescale 1ns/1ns
`default_nettype none
module alpr_store_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic store_req,
    input wire logic [7:0] store_group,
    input wire logic [7:0] store_number,
    input wire logic [1:0] store_delay,
    output logic store_ack,
    output logic store_exists,
    output logic [15:0] store_value
);
    logic [1:0] cnt_q;
    always_ff @(posedge clk) begin
        if (!nrst || !store_req || store_ack) begin
            cnt_q <= 2'h0;
            store_ack <= 1'b0;
            store_exists <= nrst & ~store_exists;
            store_value <= nrst ? ~store_value : 16'h0000;
        end else if (cnt_q == store_delay) begin
            // groups from 20h up do not exist
            store_ack <= 1'b1;
            store_exists <= store_group < 8'h20;
            store_value <= store_group < 8'h20 ? {store_group, store_number} ^ 16'h5a5a : 16'hffff;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
endmodule
`default_nettype wire

// file: sim/test_alpr_top.sv
// self-checking bench for the alarm log and parameter read block
`timescale 1ns/1ns
`default_nettype none
module test_alpr_top;
    import alpr_pkg::*;
    logic clk, nrst, alarm_new, alarm_history_send, param_read_code_wr, store_req;
    logic store_ack, store_exists, param_read_value_valid;
    alpr_byte_t alarm_code;
    logic [23:0] min_send_interval, alarm_history_output;
    logic [15:0] param_read_code_input, store_value, param_read_value_output;
    logic [7:0] store_group, store_number;
    logic [1:0] store_delay;
    int fail_count = 0, tests_run = 0, sends = 0, cyc = 0;
    logic [31:0] rows [4] = '{32'h081e_5244, 32'h0463_5e39, 32'h3001_0000, 32'h0000_5a5a};
    alpr_byte_t alarms [7] = '{8'h00, 8'h05, 8'hff, 8'h17, 8'h17, 8'h17, 8'h17};
    alpr_top dut (.*);
    alpr_store_model sm (.*);
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic stop_test;
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (alarm_history_send === 1'b1) sends <= sends + 1;
        if (cyc == 2000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic rd(logic [15:0] c);
        int n = 0;
        param_read_code_wr <= 1'b1;
        param_read_code_input <= c;
        @(posedge clk) param_read_code_wr <= 1'b0;
        while (param_read_value_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) fail_count++;
        @(posedge clk);
    endtask
    initial begin
        nrst = 0;
        alarm_new = 0;
        alarm_code = 0;
        min_send_interval = 0;
        param_read_code_wr = 0;
        param_read_code_input = 0;
        store_delay = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(alarm_history_output, 0);
        chk(param_read_value_output, 0);
        foreach (rows[i]) begin
            store_delay <= 2'(i);
            rd(rows[i][31:16]);
            chk(param_read_value_output, rows[i][15:0]);
        end
        // second write lands while the first readout waits
        store_delay <= 2'h3;
        param_read_code_wr <= 1'b1;
        param_read_code_input <= 16'h0102;
        @(posedge clk);
        rd(16'h0203);
        chk(param_read_value_output, 16'h5b58);
        foreach (alarms[i]) begin
            alarm_new <= 1'b1;
            alarm_code <= alarms[i];
            @(posedge clk) alarm_new <= 1'b0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        chk(alarm_history_output, 24'h171717);
        chk(sends, 5);
        // paced sends: the second change waits out the interval
        min_send_interval <= 24'h00000a;
        alarm_new <= 1'b1;
        alarm_code <= 8'h21;
        @(posedge clk) alarm_code <= 8'h22;
        @(posedge clk) alarm_new <= 1'b0;
        repeat (5) @(posedge clk);
        chk(sends, 6);
        repeat (9) @(posedge clk);
        chk(sends, 7);
        chk(alarm_history_output, 24'h222117);
        // reset in mid-run
        nrst <= 1'b0;
        @(posedge clk) nrst <= 1'b1;
        @(posedge clk);
        chk(alarm_history_output, 0);
        chk(param_read_value_output, 0);
        stop_test();
    end
endmodule
bind alpr_top alpr_checker #(.INTERVAL_W(INTERVAL_W)) chk_i (.*);
`default_nettype wire
